// ==== src/integer_execute_subset.sv ====
// execute-stage datapath for six integer and system instructions
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module integer_execute_subset
#(
  parameter bit HAVE_SECURITY = 1'b1,
  parameter bit HAVE_FP       = 1'b1,
  parameter bit HAVE_MAIN     = 1'b1
)
(
  input  wire logic                            sys_clk_i,
  input  wire logic                            reset_i,
  input  wire logic                            req_valid_i,
  input  wire integer_execute_pkg::exec_req_t  req_i,
  input  wire logic [31:0]                     op_a_i,
  input  wire logic [31:0]                     op_b_i,
  input  wire integer_execute_pkg::nzcv_t      flags_i,
  input  wire logic [3:0]                      greater_equal_flags_i,
  input  wire logic [31:0]                     link_register_i,
  input  wire logic                            ns_enter_i,
  input  wire logic [3:0]                      reg_addr_i,
  input  wire logic [31:0]                     reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output logic [31:0]                          reg_rdata_o,
  output logic [3:0]                           first_src_sel_o,
  output logic [3:0]                           second_src_sel_o,
  output integer_execute_pkg::exec_res_t       res_o,
  output integer_execute_pkg::side_eff_t       side_o,
  output logic                                 secure_state_o
);
  import integer_execute_pkg::*;

  function automatic logic reserved_reg(input logic [3:0] idx);
    reserved_reg = (idx == REG_STACK_IDX) || (idx == REG_PC_IDX);
  endfunction : reserved_reg

  // state
  exec_res_t   res;
  side_eff_t   side;
  logic        secure_state;
  logic        trap_enable;
  logic        unpred_seen;
  logic [31:0] rdata;
  exec_res_t   next_res;
  side_eff_t   next_side;
  logic        next_secure_state;
  logic        next_trap_enable;
  logic        next_unpred_seen;
  logic [31:0] next_rdata;

  // datapath nets
  logic [3:0]  dest_idx;
  logic [3:0]  src_a_idx;
  logic [4:0]  imm_amount;
  logic [5:0]  shift_n;
  logic [31:0] shifted;
  logic [63:0] rot_pair;
  logic [32:0] sum33;
  logic        sub_overflow;
  logic        sub_set_flags;
  logic [5:0]  field_msb;
  logic [31:0] field_left;
  logic [31:0] field_value;
  logic [31:0] quotient;
  logic [31:0] byte_sel;
  logic        regs_bad;
  logic        executes;
  logic        gateway_active;

  // narrow form: the shared three-bit field names both source and destination
  always_comb
  begin
    if (req_i.narrow)
    begin
      dest_idx  = {1'b0, req_i.dest_field[2:0]};
      src_a_idx = {1'b0, req_i.dest_field[2:0]};
    end
    else
    begin
      dest_idx  = req_i.dest_field;
      src_a_idx = req_i.first_src_field;
    end
  end

  // register file reads these in the same cycle, so they stay combinational
  assign first_src_sel_o  = src_a_idx;
  assign second_src_sel_o = req_i.second_src_field;

  // shift amount; zero encodes 32 for right shifts, narrow form shifts by 0
  assign imm_amount = {req_i.imm_high_field, req_i.imm_low_field};
  always_comb
  begin
    if (req_i.narrow)
      shift_n = 6'h00;
    else if ((imm_amount == 5'h00) &&
             ((req_i.shift_type == SHIFT_LSR) || (req_i.shift_type == SHIFT_ASR)))
      shift_n = 6'h20;
    else
      shift_n = {1'b0, imm_amount};
  end

  // barrel shifter; rotate uses a doubled word so no wrap logic is needed
  assign rot_pair = {op_b_i, op_b_i} >> shift_n;
  always_comb
  begin
    if (req_i.narrow)
      shifted = op_b_i;
    else
    begin
      unique case (req_i.shift_type)
        SHIFT_LSL: shifted = op_b_i << shift_n;
        SHIFT_LSR: shifted = op_b_i >> shift_n;
        SHIFT_ASR: shifted = 32'($signed(op_b_i) >>> shift_n);
        SHIFT_ROR:
        begin
          // amount zero with rotate is rotate-through-carry by one
          if (shift_n == 6'h00)
            shifted = {flags_i.c, op_b_i[31:1]};
          else
            shifted = rot_pair[31:0];
        end
      endcase
    end
  end

  // subtract with carry as an add of the inverted operand
  assign sum33        = {1'b0, op_a_i} + {1'b0, ~shifted} + {32'h0000_0000, flags_i.c};
  assign sub_overflow = (op_a_i[31] == ~shifted[31]) && (sum33[31] != op_a_i[31]);
  assign sub_set_flags = req_i.narrow ? !req_i.in_cond_block : req_i.set_flags;

  // field extract: lift the top bit to 31, then shift back arithmetically
  assign field_msb   = {1'b0, imm_amount} + {1'b0, req_i.width_minus_one_field};
  assign field_left  = op_a_i << (WORD_TOP - field_msb);
  assign field_value = 32'($signed(field_left) >>>
                           (WORD_TOP - {1'b0, req_i.width_minus_one_field}));

  // divide; the overflow pair is pulled out so the divider never sees it
  always_comb
  begin
    if (op_b_i == ZERO_WORD)
      quotient = ZERO_WORD;
    else if ((op_a_i == MOST_NEGATIVE) && (op_b_i == MINUS_ONE))
      quotient = MOST_NEGATIVE;
    else
      quotient = 32'($signed(op_a_i) / $signed(op_b_i));
  end

  // byte select by greater-equal flags
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      byte_sel[8*i +: 8] = greater_equal_flags_i[i] ? op_a_i[8*i +: 8]
                                                      : op_b_i[8*i +: 8];
  end

  // reserved operand registers; the narrow form cannot reach them
  always_comb
  begin
    regs_bad = 1'b0;
    unique case (req_i.op)
      OP_SUBTRACT_WITH_CARRY, OP_SIGNED_DIVIDE, OP_BYTE_SELECT:
        regs_bad = !req_i.narrow && (reserved_reg(req_i.dest_field) ||
                   reserved_reg(req_i.first_src_field) ||
                   reserved_reg(req_i.second_src_field));
      OP_SIGNED_FIELD_EXTRACT:
        regs_bad = reserved_reg(req_i.dest_field) ||
                   reserved_reg(req_i.first_src_field);
      default:
        regs_bad = 1'b0;
    endcase
  end

  // the gateway ignores the condition; everything else needs it to pass
  assign executes       = req_valid_i && req_i.cond_pass;
  assign gateway_active = req_valid_i && (req_i.op == OP_SECURE_GATEWAY) &&
                          HAVE_SECURITY && req_i.addr_secure;

  // next values of the result and side-effect registers
  always_comb
  begin
    next_res          = '0;
    next_side         = '0;
    next_res.dest     = dest_idx;
    next_res.flags    = flags_i;
    next_side.lr_data = link_register_i;
    next_secure_state = secure_state;
    if (ns_enter_i)
      next_secure_state = 1'b0;
    if (gateway_active)
    begin
      // a gateway in the same cycle as a return wins: it is the younger event
      next_secure_state = 1'b1;
      next_res.valid    = 1'b1;
      if (!secure_state)
      begin
        next_side.lr_wr      = 1'b1;
        next_side.lr_data    = {link_register_i[31:1], 1'b0};
        next_side.sfpa_clear = HAVE_FP;
      end
      next_side.cond_state_clear = HAVE_MAIN;
    end
    else if (req_valid_i && (req_i.op == OP_SECURE_GATEWAY))
      next_res.valid = 1'b1;
    else if (executes)
    begin
      next_res.valid = 1'b1;
      if (regs_bad)
        next_side.undef = 1'b1;
      else
      begin
        unique case (req_i.op)
          OP_SUBTRACT_WITH_CARRY:
          begin
            next_res.wr_en    = 1'b1;
            next_res.data     = sum33[31:0];
            next_res.flags_wr = sub_set_flags;
            if (sub_set_flags)
            begin
              next_res.flags.n = sum33[31];
              next_res.flags.z = (sum33[31:0] == ZERO_WORD);
              next_res.flags.c = sum33[32];
              next_res.flags.v = sub_overflow;
            end
          end
          OP_SIGNED_FIELD_EXTRACT:
          begin
            if (field_msb > MSB_LIMIT)
              next_side.undef = 1'b1;
            else
            begin
              next_res.wr_en = 1'b1;
              next_res.data  = field_value;
            end
          end
          OP_SIGNED_DIVIDE:
          begin
            if ((op_b_i == ZERO_WORD) && trap_enable)
              next_side.zero_div_trap = 1'b1;
            else
            begin
              next_res.wr_en = 1'b1;
              next_res.data  = quotient;
            end
          end
          OP_BYTE_SELECT:
          begin
            next_res.wr_en = 1'b1;
            next_res.data  = byte_sel;
          end
          OP_SEND_EVENT_HINT:
            next_side.send_event = 1'b1;
          default:
            next_side.undef = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      res          <= '0;
      side         <= '0;
      secure_state <= SECURE_RESET;
    end
    else
    begin
      res          <= next_res;
      side         <= next_side;
      secure_state <= next_secure_state;
    end
  end

  assign res_o          = res;
  assign side_o         = side;
  assign secure_state_o = secure_state;

  // software registers: trap enable, and a sticky unpredictable flag
  always_comb
  begin
    next_trap_enable = trap_enable;
    next_unpred_seen = unpred_seen;
    next_rdata       = ZERO_WORD;
    if (reg_wr_i && (reg_addr_i == CTRL_ADDR))
      next_trap_enable = reg_wdata_i[CTRL_TRAP_BIT];
    if (reg_wr_i && (reg_addr_i == STATUS_ADDR) && reg_wdata_i[STATUS_UNPR_BIT])
      next_unpred_seen = 1'b0;
    // a new event in the clearing cycle still sets the flag
    if (next_side.undef)
      next_unpred_seen = 1'b1;
    if (reg_rd_i)
    begin
      if (reg_addr_i == CTRL_ADDR)
        next_rdata[CTRL_TRAP_BIT] = trap_enable;
      else if (reg_addr_i == STATUS_ADDR)
      begin
        next_rdata[STATUS_SEC_BIT]  = secure_state;
        next_rdata[STATUS_UNPR_BIT] = unpred_seen;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      trap_enable <= CTRL_TRAP_RESET;
      unpred_seen <= 1'b0;
      rdata       <= ZERO_WORD;
    end
    else
    begin
      trap_enable <= next_trap_enable;
      unpred_seen <= next_unpred_seen;
      rdata       <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;

  // checks on the registered outputs against their causes one cycle before
  AST_DIV_ZERO_WRITES_ZERO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (executes && (req_i.op == OP_SIGNED_DIVIDE) && !regs_bad && (op_b_i == ZERO_WORD) &&
     !trap_enable) |=> (res_o.wr_en && (res_o.data == ZERO_WORD) && !side_o.zero_div_trap))
    else $error("divide by zero without trap did not write zero");

  AST_DIV_ZERO_TRAPS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (executes && (req_i.op == OP_SIGNED_DIVIDE) && !regs_bad && (op_b_i == ZERO_WORD) &&
     trap_enable) |=> (side_o.zero_div_trap && !res_o.wr_en))
    else $error("divide by zero with trap enabled did not trap");

  AST_DIV_MOST_NEGATIVE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (executes && (req_i.op == OP_SIGNED_DIVIDE) && !regs_bad &&
     (op_a_i == MOST_NEGATIVE) && (op_b_i == MINUS_ONE))
    |=> (res_o.data == MOST_NEGATIVE) && !res_o.flags_wr && !side_o.zero_div_trap)
    else $error("most negative over minus one gave a wrong quotient");

  AST_BYTE_SELECT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (executes && (req_i.op == OP_BYTE_SELECT) && !regs_bad)
    |=> res_o.data == (($past(op_a_i) & {{8{$past(greater_equal_flags_i[3])}},
        {8{$past(greater_equal_flags_i[2])}}, {8{$past(greater_equal_flags_i[1])}},
        {8{$past(greater_equal_flags_i[0])}}}) | ($past(op_b_i) &
        ~{{8{$past(greater_equal_flags_i[3])}}, {8{$past(greater_equal_flags_i[2])}},
        {8{$past(greater_equal_flags_i[1])}}, {8{$past(greater_equal_flags_i[0])}}})))
    else $error("byte select picked the wrong bytes");

  AST_EVENT_PULSE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    side_o.send_event |-> $past(executes && (req_i.op == OP_SEND_EVENT_HINT)) ##1
    !side_o.send_event || $past(executes && (req_i.op == OP_SEND_EVENT_HINT)))
    else $error("send event pulse without a matching hint");

  AST_GATEWAY_UNCONDITIONAL: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_valid_i && (req_i.op == OP_SECURE_GATEWAY) && !req_i.cond_pass &&
     req_i.addr_secure && HAVE_SECURITY) |=> secure_state_o)
    else $error("gateway with failed condition did not enter secure state");

  AST_GATEWAY_LINK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (gateway_active && !secure_state) |=> (side_o.lr_wr && !side_o.lr_data[0] &&
     (side_o.lr_data[31:1] == $past(link_register_i[31:1]))))
    else $error("gateway from non-secure did not clear link bit zero");

  AST_GATEWAY_NONSECURE_NOP: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_valid_i && (req_i.op == OP_SECURE_GATEWAY) && !req_i.addr_secure && !ns_enter_i)
    |=> ($stable(secure_state_o) && !side_o.lr_wr && !side_o.cond_state_clear))
    else $error("gateway at non-secure address changed state");

  AST_EXTRACT_TOP_BIT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (executes && (req_i.op == OP_SIGNED_FIELD_EXTRACT) && (field_msb > MSB_LIMIT))
    |=> (side_o.undef && !res_o.wr_en))
    else $error("field extract past bit 31 was not refused");

  AST_NARROW_FLAGS_IN_BLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (executes && (req_i.op == OP_SUBTRACT_WITH_CARRY) && req_i.narrow &&
     req_i.in_cond_block) |=> (res_o.wr_en && !res_o.flags_wr))
    else $error("narrow subtract inside a conditional block set flags");

endmodule : integer_execute_subset

// ==== src/integer_execute_pkg.sv ====
// constants, operation codes and carrier types of the integer execute subset
package integer_execute_pkg;

  // shift type codes of the subtract-with-carry register form
  localparam logic [1:0]  SHIFT_LSL        = 2'h0;
  localparam logic [1:0]  SHIFT_LSR        = 2'h1;
  localparam logic [1:0]  SHIFT_ASR        = 2'h2;
  localparam logic [1:0]  SHIFT_ROR        = 2'h3;

  // register indices that software may not name as operands
  localparam logic [3:0]  REG_STACK_IDX    = 4'hD;
  localparam logic [3:0]  REG_PC_IDX       = 4'hF;

  // highest legal bit position of a field extract
  localparam logic [5:0]  MSB_LIMIT        = 6'h1F;
  localparam logic [5:0]  WORD_TOP         = 6'h1F;

  // divide corner values
  localparam logic [31:0] MOST_NEGATIVE    = 32'h8000_0000;
  localparam logic [31:0] MINUS_ONE        = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

  // software register port map
  localparam logic [3:0]  CTRL_ADDR        = 4'h0;
  localparam logic [3:0]  STATUS_ADDR      = 4'h4;
  localparam int          CTRL_TRAP_BIT    = 0;
  localparam int          STATUS_SEC_BIT   = 0;
  localparam int          STATUS_UNPR_BIT  = 1;
  localparam logic        CTRL_TRAP_RESET  = 1'b0;
  localparam logic        SECURE_RESET     = 1'b1;

  // operation selected by the decoder
  typedef enum logic [5:0] {
    OP_SUBTRACT_WITH_CARRY = 6'b000001,
    OP_SIGNED_FIELD_EXTRACT = 6'b000010,
    OP_SIGNED_DIVIDE       = 6'b000100,
    OP_BYTE_SELECT         = 6'b001000,
    OP_SEND_EVENT_HINT     = 6'b010000,
    OP_SECURE_GATEWAY      = 6'b100000
  } op_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } nzcv_t;

  // decoded request; in the narrow form dest_field[2:0] is the shared field
  typedef struct packed {
    op_t        op;
    logic       narrow;
    logic       set_flags;
    logic [1:0] shift_type;
    logic [2:0] imm_high_field;
    logic [1:0] imm_low_field;
    logic [4:0] width_minus_one_field;
    logic [3:0] dest_field;
    logic [3:0] first_src_field;
    logic [3:0] second_src_field;
    logic       in_cond_block;
    logic       cond_pass;
    logic       addr_secure;
  } exec_req_t;

  typedef struct packed {
    logic        valid;
    logic        wr_en;
    logic [3:0]  dest;
    logic [31:0] data;
    logic        flags_wr;
    nzcv_t       flags;
  } exec_res_t;

  typedef struct packed {
    logic        zero_div_trap;
    logic        undef;
    logic        send_event;
    logic        lr_wr;
    logic [31:0] lr_data;
    logic        sfpa_clear;
    logic        cond_state_clear;
  } side_eff_t;

endpackage : integer_execute_pkg

// ==== sim/test_integer_execute_subset.sv ====
// self-checking bench for the integer execute subset
`timescale 1ns/1ps
module test_integer_execute_subset;
  import integer_execute_pkg::*;

  typedef struct {
    op_t         op;
    logic [1:0]  st;
    logic [4:0]  amt;
    logic [4:0]  wm1;
    logic [31:0] a;
    logic [31:0] b;
    logic        cin;
    logic [3:0]  ge;
    logic [35:0] exp;
  } row_t;

  logic        clk;
  logic        rst;
  logic        vld;
  exec_req_t   req;
  exec_req_t   r;
  logic [31:0] a;
  logic [31:0] b;
  nzcv_t       flg;
  logic [3:0]  ge;
  logic [31:0] lr;
  logic        ns_enter;
  logic [3:0]  raddr;
  logic [31:0] rwdata;
  logic        rwr;
  logic        rrd;
  logic [31:0] rdata;
  logic [3:0]  sel1;
  logic [3:0]  sel2;
  exec_res_t   res;
  side_eff_t   side;
  logic        sec;
  logic [31:0] got;
  int          error_cnt;
  int          n_checks;
  row_t        rows[$];
  logic [4:0]  amts[3] = '{5'h00, 5'h01, 5'h1F};

  integer_execute_subset integer_execute_subset_i (
    .sys_clk_i(clk), .reset_i(rst), .req_valid_i(vld), .req_i(req), .op_a_i(a), .op_b_i(b),
    .flags_i(flg), .greater_equal_flags_i(ge), .link_register_i(lr), .ns_enter_i(ns_enter),
    .reg_addr_i(raddr), .reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd),
    .reg_rdata_o(rdata), .first_src_sel_o(sel1), .second_src_sel_o(sel2), .res_o(res),
    .side_o(side), .secure_state_o(sec));

  // 20 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(string what, logic [35:0] e, logic [35:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // plain request with legal registers, condition passed, Secure address
  function automatic exec_req_t mk(op_t op, logic [1:0] st, logic [4:0] amt, logic [4:0] wm1);
    exec_req_t q;
    q = '0;
    q.op = op;
    q.set_flags = 1'b1;
    q.shift_type = st;
    q.imm_high_field = amt[4:2];
    q.imm_low_field = amt[1:0];
    q.width_minus_one_field = wm1;
    q.dest_field = 4'h1;
    q.first_src_field = 4'h2;
    q.second_src_field = 4'h3;
    q.cond_pass = 1'b1;
    q.addr_secure = 1'b1;
    return q;
  endfunction : mk

  // reference results {n, z, c, v, data}; amount zero on right shifts means 32
  function automatic logic [35:0] model(op_t op, logic [1:0] st, logic [4:0] amt,
      logic [4:0] wm1, logic [31:0] x, logic [31:0] y, logic c, logic [3:0] g);
    logic [31:0]        sh;
    logic [31:0]        asr;
    logic signed [31:0] t;
    logic [32:0]        s;
    logic [5:0]         msb;
    asr = $signed(y) >>> amt;
    msb = amt + wm1;
    t = x << (6'd31 - msb);
    t = t >>> (5'd31 - wm1);
    case (op)
      OP_SUBTRACT_WITH_CARRY:
      begin
        case (st)
          SHIFT_LSL: sh = y << amt;
          SHIFT_LSR: sh = (amt == 0) ? 32'h0000_0000 : y >> amt;
          SHIFT_ASR: sh = (amt == 0) ? {32{y[31]}} : asr;
          default:   sh = (amt == 0) ? {c, y[31:1]} : (y >> amt) | (y << (6'd32 - amt));
        endcase
        s = {1'b0, x} + {1'b0, ~sh} + 33'(c);
        return {s[31], s[31:0] == 32'h0000_0000, s[32], (x[31] == ~sh[31]) && (s[31] != x[31]),
                s[31:0]};
      end
      OP_SIGNED_FIELD_EXTRACT: return {4'h0, t};
      OP_SIGNED_DIVIDE:
      begin
        if (y == ZERO_WORD)
          return 36'h0_0000_0000;
        if (x == MOST_NEGATIVE && y == MINUS_ONE)
          return {4'h0, MOST_NEGATIVE};
        return {4'h0, 32'($signed(x) / $signed(y))};
      end
      default:
      begin
        for (int k = 0; k < 4; k++)
          sh[8*k+:8] = g[k] ? x[8*k+:8] : y[8*k+:8];
        return {4'h0, sh};
      end
    endcase
  endfunction : model

  task automatic add(op_t op, logic [1:0] st, logic [4:0] amt, logic [4:0] wm1,
                     logic [31:0] x, logic [31:0] y, logic c, logic [3:0] g);
    rows.push_back('{op, st, amt, wm1, x, y, c, g, model(op, st, amt, wm1, x, y, c, g)});
  endtask : add

  // one request; the answer is looked at just after the edge that takes it
  task automatic issue(exec_req_t q, logic [31:0] x, logic [31:0] y, logic c, logic [3:0] g);
    @(posedge clk);
    vld <= 1'b1;
    req <= q;
    a <= x;
    b <= y;
    // carry-in sits in the c field; the other flags stay clear
    flg <= '{n: 1'b0, z: 1'b0, c: c, v: 1'b0};
    ge <= g;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask : issue

  task automatic wr(logic [3:0] ad, logic [31:0] d);
    @(posedge clk);
    rwr <= 1'b1;
    raddr <= ad;
    rwdata <= d;
    @(posedge clk);
    rwr <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] ad);
    @(posedge clk);
    rrd <= 1'b1;
    raddr <= ad;
    @(posedge clk);
    rrd <= 1'b0;
    #1;
    got = rdata;
  endtask : rd

  // watchdog sized well above the hundred or so cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    {vld, req, a, b, flg, ge, lr, ns_enter, raddr, rwdata, rwr, rrd} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset secure", 1, sec);
    check("reset valid", 0, res.valid);
    // table: every shift type at amounts 0, 1 and 31, then corners of the other ops
    for (int s = 0; s < 4; s++)
      foreach (amts[j])
        add(OP_SUBTRACT_WITH_CARRY, 2'(s), amts[j], 5'h00, 32'h1234_5678, 32'h8000_0011,
            s[0], 4'h0);
    add(OP_SUBTRACT_WITH_CARRY, SHIFT_LSL, 5'h00, 5'h00, 32'h0000_0005, 32'h0000_0005, 1, 4'h0);
    add(OP_SUBTRACT_WITH_CARRY, SHIFT_LSL, 5'h00, 5'h00, MOST_NEGATIVE, 32'h0000_0001, 1, 4'h0);
    add(OP_SIGNED_FIELD_EXTRACT, 0, 5'h00, 5'h1F, 32'h8000_0001, 0, 0, 4'h0);
    add(OP_SIGNED_FIELD_EXTRACT, 0, 5'h1F, 5'h00, 32'h8000_0000, 0, 0, 4'h0);
    add(OP_SIGNED_FIELD_EXTRACT, 0, 5'h04, 5'h07, 32'h0000_0F80, 0, 0, 4'h0);
    add(OP_SIGNED_FIELD_EXTRACT, 0, 5'h08, 5'h03, 32'h0000_0700, 0, 0, 4'h0);
    add(OP_SIGNED_DIVIDE, 0, 0, 0, 32'h0000_0007, 32'h0000_0002, 1, 4'h0);
    add(OP_SIGNED_DIVIDE, 0, 0, 0, 32'hFFFF_FFF9, 32'h0000_0002, 1, 4'h0);
    add(OP_SIGNED_DIVIDE, 0, 0, 0, 32'hFFFF_FFF8, 32'hFFFF_FFFD, 0, 4'h0);
    add(OP_SIGNED_DIVIDE, 0, 0, 0, MOST_NEGATIVE, MINUS_ONE, 0, 4'h0);
    add(OP_SIGNED_DIVIDE, 0, 0, 0, 32'h0000_0005, ZERO_WORD, 0, 4'h0);
    for (int g = 0; g < 16; g += 5)
      add(OP_BYTE_SELECT, 0, 0, 0, 32'h1122_3344, 32'hAABB_CCDD, 0, 4'(g));
    foreach (rows[i])
    begin
      issue(mk(rows[i].op, rows[i].st, rows[i].amt, rows[i].wm1), rows[i].a, rows[i].b,
            rows[i].cin, rows[i].ge);
      check("data", rows[i].exp[31:0], res.data);
      check("write", 3'b111, {res.valid, res.wr_en, res.dest == 4'h1});
      check("flag write", rows[i].op == OP_SUBTRACT_WITH_CARRY, res.flags_wr);
      if (rows[i].op == OP_SUBTRACT_WITH_CARRY)
        check("flags", rows[i].exp[35:32], res.flags);
    end
    $display("table of %0d rows done", rows.size());
    // out-of-range field and reserved registers, twice each for a fixed outcome
    repeat (2)
    begin
      issue(mk(OP_SIGNED_FIELD_EXTRACT, 0, 5'h14, 5'h0F), 32'h1234_5678, 0, 0, 4'h0);
      check("wide field", 2'b01, {res.wr_en, side.undef});
      r = mk(OP_SIGNED_DIVIDE, 0, 0, 0);
      r.first_src_field = REG_STACK_IDX;
      issue(r, 32'h0000_0009, 32'h0000_0003, 0, 4'h0);
      check("reg 13", 2'b01, {res.wr_en, side.undef});
      r = mk(OP_BYTE_SELECT, 0, 0, 0);
      r.second_src_field = REG_PC_IDX;
      issue(r, 32'h0000_0009, 32'h0000_0003, 0, 4'h0);
      check("reg 15", 2'b01, {res.wr_en, side.undef});
    end
    rd(STATUS_ADDR);
    check("status", 32'h0000_0003, got);
    rd(4'h8);
    check("unmapped", 32'h0000_0000, got);
    $display("unpredictable cases done");
    // zero divisor with trapping enabled
    wr(CTRL_ADDR, 32'h0000_0001);
    issue(mk(OP_SIGNED_DIVIDE, 0, 0, 0), 32'h0000_0005, ZERO_WORD, 0, 4'h0);
    check("trap", 2'b10, {side.zero_div_trap, res.wr_en});
    wr(CTRL_ADDR, 32'h0000_0000);
    issue(mk(OP_SEND_EVENT_HINT, 0, 0, 0), 0, 0, 0, 4'h0);
    check("event", 1, side.send_event);
    // a failed condition leaves no answer at all
    r = mk(OP_BYTE_SELECT, 0, 0, 0);
    r.cond_pass = 1'b0;
    issue(r, 32'h0000_0009, 32'h0000_0003, 0, 4'hF);
    check("cond failed", 3'b000, {res.valid, res.wr_en, side.undef});
    $display("trap and event done");
    // narrow subtract: shared field, flags only outside a conditional block
    r = mk(OP_SUBTRACT_WITH_CARRY, 0, 0, 0);
    r.narrow = 1'b1;
    r.dest_field = 4'h5;
    for (int ib = 1; ib >= 0; ib--)
    begin
      r.in_cond_block = ib[0];
      issue(r, 32'h0000_0009, 32'h0000_0003, 1, 4'h0);
      check("narrow dest", 4'h5, res.dest);
      check("narrow flags", !ib[0], res.flags_wr);
      check("narrow data", 32'h0000_0006, res.data);
    end
    @(posedge clk);
    req <= r;
    #1;
    check("narrow source", 8'h53, {sel1, sel2});
    $display("narrow form done");
    // gateway from Non-secure state
    @(posedge clk);
    ns_enter <= 1'b1;
    lr <= 32'h0000_1235;
    @(posedge clk);
    ns_enter <= 1'b0;
    #1;
    check("left secure", 0, sec);
    r = mk(OP_SECURE_GATEWAY, 0, 0, 0);
    r.addr_secure = 1'b0;
    issue(r, 0, 0, 0, 4'h0);
    check("gateway ns addr", 2'b00, {sec, side.lr_wr});
    r.addr_secure = 1'b1;
    r.cond_pass = 1'b0;
    r.in_cond_block = 1'b1;
    issue(r, 0, 0, 0, 4'h0);
    check("gateway entry", 4'hF,
          {sec, side.lr_wr, side.sfpa_clear, side.cond_state_clear});
    check("gateway lr", 32'h0000_1234, side.lr_data);
    issue(r, 0, 0, 0, 4'h0);
    check("gateway again", 4'h9,
          {sec, side.lr_wr, side.sfpa_clear, side.cond_state_clear});
    $display("gateway done");
    report_and_stop();
  end
endmodule : test_integer_execute_subset
